// ---- src/afd_uart.sv ----
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`include "afd_regs.svh"

module afd_uart (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Avalon-MM slave
  input wire logic [17:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Serial pins
  input wire logic RXD_I,
  output logic TXD_O,
  input wire logic PORT_DATA_I,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N_O,
  // Interrupt requests
  output logic TX_EMPTY_IRQ_O,
  output logic TX_END_IRQ_O,
  output logic RX_FULL_IRQ_O,
  output logic RX_ERROR_IRQ_O
);

  afd_pkg::afd_state_s s_r;
  afd_pkg::afd_state_s s_nxt;
  logic [15:0] sel;
  logic hit;
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic [7:0] rd_val;
  logic [7:0] pre_lim;
  logic [2:0] last_bit;
  logic tx_go;
  logic tx_end;
  logic [7:0] tx_pay;
  logic rx_on;
  logic rx_line;
  logic smp;
  logic [7:0] rx_data;

  // Bus decode, shared by read mux and write paths
  assign sel = AVS_ADDRESS_I[17:2];
  assign hit = (AVS_ADDRESS_I[1:0] == 2'h0);
  assign wd = AVS_WRITEDATA_I[7:0];
  assign wr = AVS_WRITE_I & ~s_r.waitreq & AVS_BYTEENABLE_I[0] & hit;
  assign rd = AVS_READ_I & ~s_r.waitreq & hit;

  always_comb begin
    s_nxt = s_r;

    // Read mux; unmapped words read zero
    rd_val = 8'h00;
    if (hit) begin
      case (sel)
        `AFD_IDX_PINCTL: rd_val = s_r.pinctl & `AFD_PINCTL_MASK;
        `AFD_IDX_MODE: rd_val = s_r.mode;
        `AFD_IDX_BAUD: rd_val = s_r.baud;
        `AFD_IDX_CTRL: rd_val = s_r.ctrl;
        `AFD_IDX_TXBUF: rd_val = s_r.txbuf;
        `AFD_IDX_STAT: rd_val = s_r.stat;
        `AFD_IDX_RXBUF: rd_val = s_r.rxbuf;
        default: rd_val = 8'h00;
      endcase
    end

    // One wait cycle per access; data captured with it
    if ((AVS_READ_I | AVS_WRITE_I) & s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = rd_val;
    end else begin
      s_nxt.waitreq = 1'b1;
    end

    // Configuration writes
    if (wr) begin
      case (sel)
        `AFD_IDX_PINCTL: s_nxt.pinctl = wd & `AFD_PINCTL_MASK;
        `AFD_IDX_MODE: s_nxt.mode = wd;
        `AFD_IDX_BAUD: s_nxt.baud = wd;
        `AFD_IDX_CTRL: s_nxt.ctrl = wd;
        default: ;
      endcase
    end

    if (rd && sel == `AFD_IDX_STAT) begin
      s_nxt.seen = s_r.seen | s_r.rdata[7:3]; // Exactly what the master was shown
    end

    // zero clears only a seen flag; ones ignored except bit 0, written as given
    if (wr && sel == `AFD_IDX_STAT) begin
      for (int i = 0; i < 5; i++) begin
        if (!wd[i + `AFD_FLAG_LSB] && s_r.seen[i]) begin
          s_nxt.stat[i + `AFD_FLAG_LSB] = 1'b0;
          s_nxt.seen[i] = 1'b0;
        end
      end
      s_nxt.stat[`AFD_MULTI_TX] = wd[`AFD_MULTI_TX];
    end

    // Clock pin synchroniser, third stage for edge
    s_nxt.sck_q1 = SCK_I;
    s_nxt.sck_q2 = s_r.sck_q1;
    s_nxt.sck_q3 = s_r.sck_q2;

    case (s_r.mode[1:0])
      2'h0: pre_lim = `AFD_PRE_LIM0;
      2'h1: pre_lim = `AFD_PRE_LIM1;
      2'h2: pre_lim = `AFD_PRE_LIM2;
      default: pre_lim = `AFD_PRE_LIM3;
    endcase

    // divisor plus one sets tick period
    s_nxt.os_tick = 1'b0;
    if (s_r.ctrl[`AFD_CLK_EXT]) begin
      // External clock runs at sixteen times bit rate
      s_nxt.os_tick = s_r.sck_q2 & ~s_r.sck_q3;
    end else if (s_r.pre_cnt >= pre_lim) begin
      s_nxt.pre_cnt = 8'h00;
      if (s_r.brg_cnt >= s_r.baud) begin // A lowered divisor acts at once
        s_nxt.brg_cnt = 8'h00;
        s_nxt.os_tick = 1'b1;
      end else begin
        s_nxt.brg_cnt = s_r.brg_cnt + 8'h01;
      end
    end else begin
      s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
    end

    // bit-rate clock out on the clock pin
    if (s_r.os_tick) begin
      s_nxt.sck_div = s_r.sck_div + 4'h1;
    end
    s_nxt.sck_out = s_r.sck_div[3];
    s_nxt.sck_oe_n = ~(s_r.ctrl[1:0] == `AFD_CLK_INT_OUT && !s_r.mode[`AFD_MODE_SEL]);

    last_bit = s_r.mode[`AFD_CHAR_LEN] ? `AFD_LAST_BIT7 : `AFD_LAST_BIT8;

    // sync mode is not built, so it parks both paths
    tx_go = s_r.ctrl[`AFD_TX_EN] & ~s_r.mode[`AFD_MODE_SEL] & ~s_r.stat[`AFD_TX_EMPTY];
    tx_end = s_r.os_tick && s_r.tx_cnt == `AFD_LAST_TICK;
    tx_pay = s_r.mode[`AFD_CHAR_LEN] ? {1'b0, s_r.txbuf[6:0]} : s_r.txbuf;

    // Transmit sequencer
    if (s_r.tx_st != afd_pkg::TX_IDLE && s_r.os_tick) begin
      s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
    end
    case (s_r.tx_st)
      afd_pkg::TX_IDLE: begin
        if (tx_go) begin
          s_nxt.tx_st = afd_pkg::TX_START;
        end
      end
      afd_pkg::TX_START: begin
        if (tx_end) begin
          s_nxt.tx_st = afd_pkg::TX_DATA;
          s_nxt.tx_bit = 3'h0;
        end
      end
      afd_pkg::TX_DATA: begin
        if (tx_end) begin
          s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
          s_nxt.tx_bit = s_r.tx_bit + 3'h1;
          if (s_r.tx_bit == last_bit) begin
            s_nxt.tx_bit = 3'h0;
            if (s_r.mode[`AFD_PAR_ON] | s_r.mode[`AFD_MULTIPROC]) begin
              s_nxt.tx_st = afd_pkg::TX_PAR;
            end else begin
              s_nxt.tx_st = afd_pkg::TX_STOP;
            end
          end
        end
      end
      afd_pkg::TX_PAR: begin
        if (tx_end) begin
          s_nxt.tx_st = afd_pkg::TX_STOP;
          s_nxt.tx_bit = 3'h0;
        end
      end
      afd_pkg::TX_STOP: begin
        if (tx_end) begin
          if (s_r.mode[`AFD_STOP_LEN] && s_r.tx_bit == 3'h0) begin
            s_nxt.tx_bit = 3'h1;
          end else if (tx_go) begin
            s_nxt.tx_st = afd_pkg::TX_START;
          end else begin
            s_nxt.tx_st = afd_pkg::TX_IDLE;
            // done once the last stop ends
            s_nxt.stat[`AFD_TX_DONE] = 1'b1;
          end
        end
      end
      default: s_nxt.tx_st = afd_pkg::TX_IDLE;
    endcase

    // move buffer into shifter, buffer empty again
    if (s_nxt.tx_st == afd_pkg::TX_START && s_r.tx_st != afd_pkg::TX_START) begin
      s_nxt.tx_sh = tx_pay;
      s_nxt.tx_cnt = 4'h0;
      s_nxt.tx_pbit = s_r.mode[`AFD_MULTIPROC] ? s_r.stat[`AFD_MULTI_TX] :
                      (^tx_pay) ^ s_r.mode[`AFD_PAR_ODD];
      s_nxt.stat[`AFD_TX_EMPTY] = 1'b1;
      s_nxt.stat[`AFD_TX_DONE] = 1'b0;
    end

    // idle high, start low, LSB first, stops high
    case (s_nxt.tx_st)
      afd_pkg::TX_START: s_nxt.tx_line = 1'b0;
      afd_pkg::TX_DATA: s_nxt.tx_line = s_nxt.tx_sh[0];
      afd_pkg::TX_PAR: s_nxt.tx_line = s_nxt.tx_pbit;
      default: s_nxt.tx_line = 1'b1;
    endcase

    if (wr && sel == `AFD_IDX_TXBUF) begin
      s_nxt.txbuf = wd;
      s_nxt.stat[`AFD_TX_EMPTY] = 1'b0;
    end

    // Receive pin synchroniser
    s_nxt.rx_q1 = RXD_I;
    s_nxt.rx_q2 = s_r.rx_q1;
    rx_line = s_r.rx_q2 ^ s_r.pinctl[`AFD_RX_INV];
    s_nxt.rx_prev = rx_line;

    rx_on = s_r.ctrl[`AFD_RX_EN] & ~s_r.mode[`AFD_MODE_SEL];
    // eighth of sixteen ticks is bit centre
    smp = s_r.os_tick && s_r.rx_cnt == `AFD_SAMPLE_TICK;
    rx_data = s_r.mode[`AFD_CHAR_LEN] ? {1'b0, s_r.rx_sh[7:1]} : s_r.rx_sh;

    // Receive sequencer
    if (s_r.rx_st != afd_pkg::RX_IDLE && s_r.os_tick) begin
      s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
    end
    case (s_r.rx_st)
      afd_pkg::RX_IDLE: begin
        if (rx_on && s_r.rx_prev && !rx_line) begin
          s_nxt.rx_st = afd_pkg::RX_START;
          s_nxt.rx_cnt = 4'h0;
        end
      end
      afd_pkg::RX_START: begin
        // Glitch filter: high at centre aborts
        if (smp) begin
          s_nxt.rx_st = rx_line ? afd_pkg::RX_IDLE : afd_pkg::RX_DATA;
          s_nxt.rx_bit = 3'h0;
        end
      end
      afd_pkg::RX_DATA: begin
        if (smp) begin
          s_nxt.rx_sh = {rx_line, s_r.rx_sh[7:1]};
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == last_bit) begin
            if (s_r.mode[`AFD_PAR_ON] | s_r.mode[`AFD_MULTIPROC]) begin
              s_nxt.rx_st = afd_pkg::RX_PAR;
            end else begin
              s_nxt.rx_st = afd_pkg::RX_STOP;
            end
          end
        end
      end
      afd_pkg::RX_PAR: begin
        if (smp) begin
          s_nxt.rx_pbit = rx_line;
          s_nxt.rx_st = afd_pkg::RX_STOP;
        end
      end
      afd_pkg::RX_STOP: begin
        if (smp) begin
          s_nxt.rx_st = afd_pkg::RX_IDLE;
          if (s_r.stat[`AFD_RX_FULL]) begin
            s_nxt.stat[`AFD_OVERRUN] = 1'b1;
          end else begin
            s_nxt.rxbuf = rx_data;
            s_nxt.stat[`AFD_RX_FULL] = 1'b1;
            // low stop bit is a framing error
            if (!rx_line) begin
              s_nxt.stat[`AFD_FRAMING] = 1'b1;
            end
            // parity check against odd or even
            if (s_r.mode[`AFD_PAR_ON] && !s_r.mode[`AFD_MULTIPROC] &&
                s_r.rx_pbit != ((^rx_data) ^ s_r.mode[`AFD_PAR_ODD])) begin
              s_nxt.stat[`AFD_PAR_ERR] = 1'b1;
            end
            if (s_r.mode[`AFD_MULTIPROC]) begin
              s_nxt.stat[`AFD_MULTI_RX] = s_r.rx_pbit;
            end
          end
        end
      end
      default: s_nxt.rx_st = afd_pkg::RX_IDLE;
    endcase
    if (!rx_on) begin
      s_nxt.rx_st = afd_pkg::RX_IDLE;
    end

    // pin carries port data or serial output
    s_nxt.txd = s_r.pinctl[`AFD_TX_PIN_SEL] ?
                (s_nxt.tx_line ^ s_r.pinctl[`AFD_TX_INV]) : PORT_DATA_I;

    s_nxt.irq_txe = s_r.ctrl[`AFD_TX_IRQ_EN] & s_r.stat[`AFD_TX_EMPTY];
    s_nxt.irq_tx_done = s_r.ctrl[`AFD_TX_END_IRQ_EN] & s_r.stat[`AFD_TX_DONE];
    s_nxt.irq_rxf = s_r.ctrl[`AFD_RX_IRQ_EN] & s_r.stat[`AFD_RX_FULL];
    s_nxt.irq_err = s_r.ctrl[`AFD_RX_IRQ_EN] & (|s_r.stat[5:3]);
  end

  // State register; reset wins over enable, enable low freezes everything else
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s_r <= '0;
      s_r.mode <= `AFD_RST_MODE;
      s_r.baud <= `AFD_RST_BAUD;
      s_r.ctrl <= `AFD_RST_CTRL;
      s_r.txbuf <= `AFD_RST_TXBUF;
      s_r.stat <= `AFD_RST_STAT;
      s_r.pinctl <= `AFD_RST_PINCTL;
      s_r.sck_q1 <= 1'b1;
      s_r.sck_q2 <= 1'b1;
      s_r.sck_q3 <= 1'b1;
      s_r.rx_q1 <= 1'b1;
      s_r.rx_q2 <= 1'b1;
      s_r.rx_prev <= 1'b1;
      s_r.tx_line <= 1'b1;
      s_r.waitreq <= 1'b1;
      s_r.sck_oe_n <= 1'b1;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign AVS_READDATA_O = {24'h000000, s_r.rdata};
  assign AVS_WAITREQUEST_O = s_r.waitreq;
  assign TXD_O = s_r.txd;
  assign SCK_O = s_r.sck_out;
  assign SCK_OE_N_O = s_r.sck_oe_n;
  assign TX_EMPTY_IRQ_O = s_r.irq_txe;
  assign TX_END_IRQ_O = s_r.irq_tx_done;
  assign RX_FULL_IRQ_O = s_r.irq_rxf;
  assign RX_ERROR_IRQ_O = s_r.irq_err;

endmodule : afd_uart

// ---- src/afd_regs.svh ----
`ifndef AFD_REGS_SVH
`define AFD_REGS_SVH
// Overview of operation
// - Mode bit 7 selects async; set (sync) parks both paths
// - Bit 6 selects eight or seven data
// - Bit 5 enables parity generate and check
// - Bit 4 selects even or odd parity
// - Bit 3 selects one or two stops
// - Bit 2 enables multiprocessor bit
// - Prescale zero divides clock by four
// - Divisor register sets bit rate
// - Control bit 5 enables transmit
// - Control bit 4 enables receive
// - Clock source 01 drives clock pin
// - Empty flag low while data waits
// - Full flag set on stored character
// - Overrun sets status bit 5
// - Framing error sets status bit 4
// - Parity error sets status bit 3
// - Done flag low while sending
// - Eight-bit transmit buffer register
// - Eight-bit receive buffer register
// - Pin select routes port or transmit
// - Invert bit flips transmit output
// - Invert bit flips receive input
// - Idle high, start, LSB first, stops
// - Start edge sync, sample eighth tick
// - Flags cleared by zero after read
// - Four requests gated by enables

// Register indices; byte address is four times the index
`define AFD_IDX_PINCTL 16'hFF91
`define AFD_IDX_MODE 16'hFFA8
`define AFD_IDX_BAUD 16'hFFA9
`define AFD_IDX_CTRL 16'hFFAA
`define AFD_IDX_TXBUF 16'hFFAB
`define AFD_IDX_STAT 16'hFFAC
`define AFD_IDX_RXBUF 16'hFFAD

// Frame mode fields
`define AFD_MODE_SEL 7
`define AFD_CHAR_LEN 6
`define AFD_PAR_ON 5
`define AFD_PAR_ODD 4
`define AFD_STOP_LEN 3
`define AFD_MULTIPROC 2

// Control fields
`define AFD_TX_IRQ_EN 7
`define AFD_RX_IRQ_EN 6
`define AFD_TX_EN 5
`define AFD_RX_EN 4
`define AFD_TX_END_IRQ_EN 2
`define AFD_CLK_EXT 1
`define AFD_CLK_INT_OUT 2'h1

// Status fields
`define AFD_TX_EMPTY 7
`define AFD_RX_FULL 6
`define AFD_OVERRUN 5
`define AFD_FRAMING 4
`define AFD_PAR_ERR 3
`define AFD_TX_DONE 2
`define AFD_MULTI_RX 1
`define AFD_MULTI_TX 0
`define AFD_FLAG_LSB 3

// Pin control fields
`define AFD_TX_PIN_SEL 5
`define AFD_TX_INV 3
`define AFD_RX_INV 2
`define AFD_PINCTL_MASK 8'h2C

// Reset values
`define AFD_RST_MODE 8'h00
`define AFD_RST_BAUD 8'hFF
`define AFD_RST_CTRL 8'h00
`define AFD_RST_TXBUF 8'hFF
`define AFD_RST_STAT 8'h84
`define AFD_RST_PINCTL 8'h00

// Timing: prescaler limits give 4 * 4^n clocks per stage
`define AFD_PRE_LIM0 8'h03
`define AFD_PRE_LIM1 8'h0F
`define AFD_PRE_LIM2 8'h3F
`define AFD_PRE_LIM3 8'hFF
`define AFD_SAMPLE_TICK 4'h7
`define AFD_LAST_TICK 4'hF
`define AFD_LAST_BIT8 3'h7
`define AFD_LAST_BIT7 3'h6
`endif

// ---- src/afd_pkg.sv ----
package afd_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} afd_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} afd_rx_e;

  // Whole state of the transceiver
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] ctrl;
    logic [7:0] txbuf;
    logic [7:0] stat;
    logic [7:0] pinctl;
    logic [7:0] rxbuf;
    logic [4:0] seen;
    logic [7:0] pre_cnt;
    logic [7:0] brg_cnt;
    logic os_tick;
    logic [3:0] sck_div;
    logic sck_q1;
    logic sck_q2;
    logic sck_q3;
    logic rx_q1;
    logic rx_q2;
    logic rx_prev;
    afd_tx_e tx_st;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_pbit;
    logic tx_line;
    afd_rx_e rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pbit;
    logic waitreq;
    logic [7:0] rdata;
    logic txd;
    logic sck_out;
    logic sck_oe_n;
    logic irq_txe;
    logic irq_tx_done;
    logic irq_rxf;
    logic irq_err;
  } afd_state_s;
endpackage : afd_pkg

// ---- dv/afd_uart_chk.sv ----
`timescale 1ns/1ns
`include "afd_regs.svh"
module afd_uart_chk (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Register bus
  input wire logic [17:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Pins and requests
  input wire logic TXD_O,
  input wire logic PORT_DATA_I,
  input wire logic SCK_OE_N_O,
  input wire logic TX_EMPTY_IRQ_O,
  input wire logic TX_END_IRQ_O,
  input wire logic RX_FULL_IRQ_O,
  input wire logic RX_ERROR_IRQ_O
);
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic pin_sel_r;
  logic wr_ok;
  logic drive_clk;
  // Completed byte write; only such writes move the shadows
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && CE_I && AVS_BYTEENABLE_I[0]
    && AVS_ADDRESS_I[1:0] == 2'h0;
  assign drive_clk = !mode_r[`AFD_MODE_SEL] && ctrl_r[1:0] == `AFD_CLK_INT_OUT;
  // Shadow registers, since the checker sees no internal state
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_r <= 8'h00;
      ctrl_r <= 8'h00;
      pin_sel_r <= 1'b0;
    end else if (wr_ok) begin
      if (AVS_ADDRESS_I[17:2] == `AFD_IDX_MODE) mode_r <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I[17:2] == `AFD_IDX_CTRL) ctrl_r <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I[17:2] == `AFD_IDX_PINCTL) pin_sel_r <= AVS_WRITEDATA_I[5];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Bus handshake steps
  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I;
  endsequence
  sequence s_answer;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus answer not a single cycle");
  chk_bus_idle: assert property (!AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low without request");
  chk_read_upper: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_reset_quiet: assert property ($rose(RST_N_I) |-> AVS_WAITREQUEST_O && SCK_OE_N_O
    && !TX_EMPTY_IRQ_O && !TX_END_IRQ_O && !RX_FULL_IRQ_O && !RX_ERROR_IRQ_O)
    else $error("outputs not quiet after reset");
  chk_port_pass: assert property (!pin_sel_r && CE_I |=> TXD_O == $past(PORT_DATA_I))
    else $error("port value not on shared pin");
  chk_clk_drive: assert property (drive_clk |=> !SCK_OE_N_O)
    else $error("clock pin not driven");
  chk_clk_release: assert property (!drive_clk |=> SCK_OE_N_O)
    else $error("clock pin driven");
  chk_end_mask: assert property (!ctrl_r[`AFD_TX_END_IRQ_EN] |=> !TX_END_IRQ_O)
    else $error("end request while masked");
  chk_empty_mask: assert property (!ctrl_r[`AFD_TX_IRQ_EN] |=> !TX_EMPTY_IRQ_O)
    else $error("empty request while masked");
  chk_rx_mask: assert property (!ctrl_r[`AFD_RX_IRQ_EN] |=>
    !RX_FULL_IRQ_O && !RX_ERROR_IRQ_O)
    else $error("receive request while masked");
endmodule : afd_uart_chk

bind afd_uart afd_uart_chk i_chk (.*);

// ---- dv/afd_peer.sv ----
`timescale 1ns/1ns
module afd_peer (
  // Clock and serial lines
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int bit_cyc = 64;
  int low_len = 0;
  int cyc = 0;
  logic inv = 1'b0;
  logic [12:0] got = '1;
  // Cycle count for bit centres
  always @(posedge clk_i) cyc <= cyc + 1;
  initial line_o = 1'b1;
  // start low, LSB first, stops high
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i] ^ inv;
      repeat (bit_cyc) @(posedge clk_i);
    end
  endtask : send
  // sample each bit after start at its centre
  task automatic recv(input int n);
    int t0;
    got = '1;
    got[0] = 1'b0;
    @(posedge clk_i iff (line_i ^ inv) === 1'b0);
    t0 = cyc;
    low_len = 0;
    // Capped so a low first data bit cannot swallow its centre
    while ((line_i ^ inv) === 1'b0 && low_len < bit_cyc + 8) begin
      @(posedge clk_i);
      low_len++;
    end
    for (int i = 1; i < n; i++) begin
      while (cyc < t0 + bit_cyc / 2 + i * bit_cyc) @(posedge clk_i);
      got[i] = line_i ^ inv;
    end
  endtask : recv
endmodule : afd_peer

// ---- dv/afd_uart_tb.sv ----
`timescale 1ns/1ns
`include "afd_regs.svh"
module afd_uart_tb;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic [17:0] addr = 18'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic port_d = 1'b0;
  logic [31:0] rdata;
  logic waitreq, txd, rxd, sck, irq_txe, irq_tx_done, irq_rxf, irq_err;
  logic mp_rx = 1'b0;
  logic [7:0] modes [5] = '{8'h30, 8'h20, 8'h48, 8'h00, 8'h04};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  // 100 MHz clock
  always #5 CLK_I = ~CLK_I;
  afd_uart i_dut (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(1'b1), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF),
    .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .RXD_I(rxd), .TXD_O(txd), .PORT_DATA_I(port_d), .SCK_I(1'b0), .SCK_O(sck),
    .SCK_OE_N_O(), .TX_EMPTY_IRQ_O(irq_txe), .TX_END_IRQ_O(irq_tx_done),
    .RX_FULL_IRQ_O(irq_rxf), .RX_ERROR_IRQ_O(irq_err));
  afd_peer i_peer (.clk_i(CLK_I), .line_i(txd), .line_o(rxd));

  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  // One access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge CLK_I);
    addr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge CLK_I); while (waitreq !== 1'b0);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg
  task automatic creg(input string nm, input logic [15:0] idx, input logic [7:0] e,
                      input logic [7:0] m);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(nm, {24'h0, e & m}, {24'h0, q & m});
  endtask : creg
  // Expected line bits of one character plus one idle bit
  function automatic logic [12:0] frame(input logic [7:0] d, input logic [7:0] m,
                                        input logic bp, input logic bs);
    logic [12:0] f;
    int j;
    f = '1;
    f[0] = 1'b0;
    j = m[6] ? 7 : 8;
    for (int i = 0; i < j; i++) f[i + 1] = d[i];
    j++;
    if (m[2]) begin
      f[j] = 1'b1;
      j++;
    end else if (m[5]) begin
      f[j] = ^(d & (m[6] ? 8'h7F : 8'hFF)) ^ m[4] ^ bp;
      j++;
    end
    f[j] = ~bs;
    return f;
  endfunction : frame
  function automatic int nbits(input logic [7:0] m);
    return 10 - int'(m[6]) + int'(m[5] | m[2]) + int'(m[3]);
  endfunction : nbits

  task automatic t_regs;
    logic [15:0] idx [8] = '{`AFD_IDX_MODE, `AFD_IDX_BAUD, `AFD_IDX_CTRL, `AFD_IDX_TXBUF,
                             `AFD_IDX_STAT, `AFD_IDX_PINCTL, `AFD_IDX_RXBUF, 16'hFF90};
    logic [7:0] rv [8] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) creg("reset value", idx[i], rv[i], 8'hFF);
    wreg(`AFD_IDX_RXBUF, 8'h5A);
    creg("rx buffer", `AFD_IDX_RXBUF, 8'h00, 8'hFF);
    wreg(`AFD_IDX_STAT, 8'hFE);
    creg("status ones", `AFD_IDX_STAT, 8'h84, 8'hFE);
  endtask : t_regs
  task automatic t_port;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK_I);
      port_d <= i[0];
      repeat (2) @(posedge CLK_I);
      check("port pin", {31'h0, i[0]}, {31'h0, txd});
    end
  endtask : t_port
  // Two back-to-back characters out while one comes in
  task automatic t_duplex(input logic [7:0] m, input logic [7:0] pin);
    int n;
    n = nbits(m);
    wreg(`AFD_IDX_MODE, m);
    wreg(`AFD_IDX_BAUD, 8'h00);
    wreg(`AFD_IDX_PINCTL, pin);
    wreg(`AFD_IDX_CTRL, 8'h31);
    if (m[2]) wreg(`AFD_IDX_STAT, 8'hFF);
    fork
      begin
        i_peer.recv(n);
        check("tx frame", {19'h0, frame(8'hA5, m, 0, 0)}, {19'h0, i_peer.got});
        i_peer.recv(n);
        check("tx next", {19'h0, frame(8'h3C, m, 0, 0)}, {19'h0, i_peer.got});
      end
      begin
        wreg(`AFD_IDX_TXBUF, 8'hA5);
        wreg(`AFD_IDX_TXBUF, 8'h3C);
        creg("pending", `AFD_IDX_STAT, 8'h00, 8'h84);
        i_peer.send(frame(8'hC3, m, 0, 0), n + 1);
      end
    join
    repeat (80) @(posedge CLK_I);
    creg("rx data", `AFD_IDX_RXBUF, 8'hC3 & (m[6] ? 8'h7F : 8'hFF), 8'hFF);
    // Received multiprocessor bit stays until the next such frame
    mp_rx = mp_rx | m[2];
    creg("status", `AFD_IDX_STAT, {6'h31, mp_rx, 1'b0}, 8'hFE);
    wreg(`AFD_IDX_STAT, 8'hBE);
    creg("cleared", `AFD_IDX_STAT, 8'h84, 8'hFC);
  endtask : t_duplex
  task automatic t_rx_err;
    wreg(`AFD_IDX_MODE, 8'h30);
    wreg(`AFD_IDX_CTRL, 8'hF5);
    for (int i = 0; i < 2; i++) begin
      i_peer.send(frame(8'h11, 8'h30, !i[0], i[0]), 12);
      check("requests", {28'h0, irq_txe, irq_tx_done, irq_rxf, irq_err}, 32'hF);
      creg("error flag", `AFD_IDX_STAT, i[0] ? 8'h50 : 8'h48, 8'h78);
      wreg(`AFD_IDX_STAT, 8'h86);
    end
    creg("errors clear", `AFD_IDX_STAT, 8'h00, 8'h78);
    check("requests off", {28'h0, irq_txe, irq_tx_done, irq_rxf, irq_err}, 32'hC);
    i_peer.send(frame(8'h5A, 8'h30, 0, 0), 12);
    i_peer.send(frame(8'hA5, 8'h30, 0, 0), 12);
    creg("overrun", `AFD_IDX_STAT, 8'h60, 8'h78);
    creg("kept", `AFD_IDX_RXBUF, 8'h5A, 8'hFF);
    wreg(`AFD_IDX_STAT, 8'h86);
  endtask : t_rx_err
  task automatic t_off;
    int lows;
    int rises;
    logic sck_d;
    lows = 0;
    rises = 0;
    wreg(`AFD_IDX_CTRL, 8'h01);
    wreg(`AFD_IDX_TXBUF, 8'h96);
    sck_d = sck;
    fork
      i_peer.send(frame(8'h77, 8'h30, 0, 0), 12);
      repeat (700) begin
        @(posedge CLK_I);
        lows += int'(!txd);
        rises += int'(sck && !sck_d);
        sck_d = sck;
      end
    join
    check("tx held", lows, 0);
    check("clock out rate", rises >= 10 && rises <= 11, 1);
    creg("rx held", `AFD_IDX_STAT, 8'h00, 8'h40);
    fork
      i_peer.recv(11);
      wreg(`AFD_IDX_CTRL, 8'h31);
    join
    check("tx freed", {19'h0, frame(8'h96, 8'h30, 0, 0)}, {19'h0, i_peer.got});
    repeat (40) @(posedge CLK_I);
    // Sync mode is not built, so it must park the transmitter
    wreg(`AFD_IDX_MODE, 8'hB0);
    wreg(`AFD_IDX_TXBUF, 8'h69);
    repeat (100) begin
      @(posedge CLK_I);
      lows += int'(!txd);
    end
    check("sync held", lows, 0);
    fork
      i_peer.recv(11);
      wreg(`AFD_IDX_MODE, 8'h30);
    join
    check("sync freed", {19'h0, frame(8'h69, 8'h30, 0, 0)}, {19'h0, i_peer.got});
    repeat (40) @(posedge CLK_I);
  endtask : t_off
  // Divisor 4 with prescale zero: tick every 20 clocks
  task automatic t_rate;
    int bit_len;
    bit_len = 4 * (4 + 1) * 16;
    i_peer.bit_cyc = bit_len;
    wreg(`AFD_IDX_BAUD, 8'h04);
    fork
      i_peer.recv(11);
      wreg(`AFD_IDX_TXBUF, 8'h01);
    join
    check("slow frame", {19'h0, frame(8'h01, 8'h30, 0, 0)}, {19'h0, i_peer.got});
    check("start len", i_peer.low_len >= bit_len - 22 && i_peer.low_len <= bit_len + 2, 1);
    repeat (200) @(posedge CLK_I);
    i_peer.bit_cyc = 64;
  endtask : t_rate
  // Receiver off while both lines flip polarity
  task automatic t_inv;
    wreg(`AFD_IDX_CTRL, 8'h21);
    wreg(`AFD_IDX_PINCTL, 8'h2C);
    i_peer.inv = 1'b1;
    i_peer.send(13'h1FFF, 1);
    t_duplex(8'h30, 8'h2C);
  endtask : t_inv

  // Watchdog
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      close_out;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_regs;
    t_port;
    for (int i = 0; i < 5; i++) t_duplex(modes[i], 8'h20);
    t_rx_err;
    t_off;
    t_rate;
    t_inv;
    close_out;
  end
endmodule : afd_uart_tb
